// file: design/acc_defines.vh
// Constants for the analog comparator controller: offsets, fields, resets.
// Assumes a 10 MHz peripheral clock and a 32-bit APB register bus.
//
// Summary of operation
// - Drive two eight-way input selects, plus and minus.
// - Writing the select fields puts the selected I/O lines in analog mode.
// - A matching output edge sets the comparison flag and requests interrupt.
// - Any write to mode or analog control register starts masking.
// - Current select 0 gives a masking period of 8 clocks.
// - Current select 1 gives a masking period of 128 clocks.
// - Status reads return bit 31 set while masking runs.
// - In fault mode, match events drive the fault output to the PWM.
// - Fault source is combinational or clock-resynchronized.
// - With protection enabled, writes to protected registers are ignored.
// - A blocked write sets violation flag and records the register offset.
// - Reading the protection status register clears the violation flag.
// - Protected set is the mode and analog control registers only.
// - Hold hysteresis and speed settings and drive them to the cell.
// - Edge type 0 rising, 1 falling, 2 any edge.
// - Fault enable 0 holds fault low; 1 follows flag or output.
// - Edge flag set by a selected edge, cleared on status read.
// - Invert bit flips comparator output before all processing.
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ACC_OFS_CTRL     8'h00
`define ACC_OFS_MODE     8'h04
`define ACC_OFS_IEN      8'h24
`define ACC_OFS_IDIS     8'h28
`define ACC_OFS_IMASK    8'h2c
`define ACC_OFS_STATUS   8'h30
`define ACC_OFS_ANALOG   8'h94
`define ACC_OFS_PMODE    8'he4
`define ACC_OFS_PSTAT    8'he8

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define COMPARATOR_MODE_REG_MINUS_LSB 0
`define COMPARATOR_MODE_REG_PLUS_LSB  4
`define COMPARATOR_MODE_REG_EN_BIT    8
`define COMPARATOR_MODE_REG_EDGE_LSB  9
`define COMPARATOR_MODE_REG_INV_BIT   12
`define COMPARATOR_MODE_REG_FSRC_BIT  13
`define COMPARATOR_MODE_REG_FEN_BIT   14
`define ACC_AC_CURRENT_SELECT_BIT_BIT  0
`define ACC_AC_HYST_LSB  1
`define ACC_ST_MASK_BIT  31
`define ACC_WP_KEY_LSB   8
`define ACC_WP_SRC_LSB   8

// ----------------------------------------------------------------------
// Values and reset states
// ----------------------------------------------------------------------
`define ACC_EDGE_RISE    2'h0
`define ACC_EDGE_FALL    2'h1
`define ACC_EDGE_ANY     2'h2
`define ACC_WP_KEY       24'h414343
`define COMPARATOR_MODE_REG_RESET     15'h0000
`define ACC_AC_RESET     3'h0
`define ACC_MASK_SHORT   8'h08
`define ACC_MASK_LONG    8'h80

`endif

// file: design/acc_sync.v
// Two-stage synchronizer for the comparator output.
// Assumes the input is asynchronous to i_mclk.
module acc_sync (
	// Clock and reset
	input  wire i_mclk,
	input  wire i_rst_b,
	// Data
	input  wire i_async,
	output wire o_sync
);
	reg meta_q;
	reg sync_q;

	// ------------------------------------------------------------------
	// Stages
	// ------------------------------------------------------------------
	always @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule // acc_sync

// file: design/acc_mask_timer.v
// Output masking timer: loads on a settings write, counts down.
// Assumes a single-cycle start pulse.
`include "acc_defines.vh"
module acc_mask_timer (
	// Clock and reset
	input  wire i_mclk,
	input  wire i_rst_b,
	// Control
	input  wire i_start,
	input  wire i_long,
	output wire o_active
);
	reg [7:0] cnt_q;
	reg [7:0] cnt_d;

	// ------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------
	always @* begin
		cnt_d = cnt_q;
		if (i_start)
			cnt_d = i_long ? `ACC_MASK_LONG : `ACC_MASK_SHORT;
		else if (cnt_q != 8'h00)
			cnt_d = cnt_q - 8'h01;
	end

	always @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b)
			cnt_q <= 8'h00;
		else
			cnt_q <= cnt_d;
	end

	assign o_active = (cnt_q != 8'h00);
endmodule // acc_mask_timer

// file: design/acc_ctrl.v
// Analog comparator controller top: APB registers, edge flag, fault out.
// Assumes an APB master on i_mclk and an asynchronous comparator output.
//
// The implementer's own choices: the register offsets and the APB register port.
`include "acc_defines.vh"
module acc_ctrl (
	// Clock and reset
	input  wire        i_mclk,
	input  wire        i_rst_b,
	// APB slave
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [7:0]  i_paddr,
	input  wire [31:0] i_pwdata,
	output wire        o_pready,
	output wire        o_pslverr,
	output reg  [31:0] o_prdata,
	// Analog cell
	input  wire        i_cmp_out,
	output wire [2:0]  o_plus_input_select,
	output wire [2:0]  o_minus_input_select,
	output wire        o_cmp_enable,
	output wire        o_speed_low_power,
	output wire [1:0]  o_hysteresis,
	output reg         o_sel_analog_pulse,
	// Fault, interrupt
	output wire        o_fault,
	output wire        o_irq
);
	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	reg [14:0] comparator_mode_q;
	reg [2:0]  analog_control_q;
	reg        protect_enable_bit_q;
	reg        protect_violation_flag_q;
	reg [7:0]  violation_offset_field_q;
	reg        irq_mask_q;
	reg        edge_flag_q;
	reg        sync_prev_q;
	reg [31:0] rdata_d;

	wire       wr_acc;
	wire       rd_acc;
	wire       is_prot;
	wire       wr_blocked;
	wire       wr_ok;
	wire       flip;
	wire       cmp_pol;
	wire       cmp_sync;
	wire       masking;
	wire [1:0] edge_type_field;
	wire       rise;
	wire       fall;
	wire       edge_hit;
	wire       soft_rst;
	wire       mask_long;

	function edge_match;
		input [1:0] typ;
		input       r;
		input       f;
		begin
			case (typ)
				`ACC_EDGE_RISE: edge_match = r;
				`ACC_EDGE_FALL: edge_match = f;
				`ACC_EDGE_ANY:  edge_match = r | f;
				default:        edge_match = 1'b0;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	assign o_pready  = 1'b1;
	assign o_pslverr = 1'b0;
	assign wr_acc    = i_psel & i_penable & i_pwrite;
	assign rd_acc    = i_psel & i_penable & ~i_pwrite;
	assign is_prot   = (i_paddr == `ACC_OFS_MODE) |
	                   (i_paddr == `ACC_OFS_ANALOG);
	assign wr_blocked = wr_acc & is_prot & protect_enable_bit_q;
	assign wr_ok     = wr_acc & ~wr_blocked;
	assign soft_rst  = wr_acc & (i_paddr == `ACC_OFS_CTRL) & i_pwdata[0];
	// Masking length follows an accepted current select write, else the stored current select
	assign mask_long = (wr_ok && i_paddr == `ACC_OFS_ANALOG) ?
	                   i_pwdata[`ACC_AC_CURRENT_SELECT_BIT_BIT] :
	                   analog_control_q[`ACC_AC_CURRENT_SELECT_BIT_BIT];

	// ------------------------------------------------------------------
	// Comparator path
	// ------------------------------------------------------------------
	assign flip    = comparator_mode_q[`COMPARATOR_MODE_REG_INV_BIT];
	assign cmp_pol = i_cmp_out ^ flip;

	acc_sync u_sync (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_async (cmp_pol),
		.o_sync  (cmp_sync)
	);

	acc_mask_timer u_mask (
		.i_mclk   (i_mclk),
		.i_rst_b  (i_rst_b),
		.i_start  (wr_acc & is_prot),
		.i_long   (mask_long),
		.o_active (masking)
	);

	assign edge_type_field = comparator_mode_q[`COMPARATOR_MODE_REG_EDGE_LSB +: 2];
	assign rise     = cmp_sync & ~sync_prev_q;
	assign fall     = ~cmp_sync & sync_prev_q;
	assign edge_hit = edge_match(edge_type_field, rise, fall) & ~masking &
	                  comparator_mode_q[`COMPARATOR_MODE_REG_EN_BIT];

	// ------------------------------------------------------------------
	// Register writes and flags
	// ------------------------------------------------------------------
	always @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			comparator_mode_q        <= `COMPARATOR_MODE_REG_RESET;
			analog_control_q         <= `ACC_AC_RESET;
			protect_enable_bit_q     <= 1'b0;
			protect_violation_flag_q <= 1'b0;
			violation_offset_field_q <= 8'h00;
			irq_mask_q               <= 1'b0;
			edge_flag_q              <= 1'b0;
			sync_prev_q              <= 1'b0;
			o_sel_analog_pulse       <= 1'b0;
		end else begin
			sync_prev_q        <= cmp_sync;
			o_sel_analog_pulse <= 1'b0;
			if (soft_rst) begin
				comparator_mode_q <= `COMPARATOR_MODE_REG_RESET;
				analog_control_q  <= `ACC_AC_RESET;
				irq_mask_q        <= 1'b0;
			end
			if (wr_ok && i_paddr == `ACC_OFS_MODE) begin
				comparator_mode_q  <= i_pwdata[14:0];
				o_sel_analog_pulse <= 1'b1;
			end
			if (wr_ok && i_paddr == `ACC_OFS_ANALOG)
				analog_control_q <= i_pwdata[2:0];
			if (wr_acc && i_paddr == `ACC_OFS_PMODE &&
			    i_pwdata[31:8] == `ACC_WP_KEY)
				protect_enable_bit_q <= i_pwdata[0];
			if (wr_acc && i_paddr == `ACC_OFS_IEN && i_pwdata[0])
				irq_mask_q <= 1'b1;
			else if (wr_acc && i_paddr == `ACC_OFS_IDIS && i_pwdata[0])
				irq_mask_q <= 1'b0;
			// Set wins over read clear
			if (wr_blocked) begin
				protect_violation_flag_q <= 1'b1;
				violation_offset_field_q <= i_paddr;
			end else if (rd_acc && i_paddr == `ACC_OFS_PSTAT &&
			             o_prdata[0])
				protect_violation_flag_q <= 1'b0;
			if (edge_hit)
				edge_flag_q <= 1'b1;
			// Only a flag already latched for the reader is cleared
			else if (rd_acc && i_paddr == `ACC_OFS_STATUS &&
			         o_prdata[0])
				edge_flag_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------
	always @* begin
		rdata_d = 32'h00000000;
		case (i_paddr)
			`ACC_OFS_MODE:   rdata_d = {17'h00000, comparator_mode_q};
			`ACC_OFS_IMASK:  rdata_d = {31'h00000000, irq_mask_q};
			`ACC_OFS_STATUS: rdata_d = {masking, 29'h00000000,
			                            cmp_sync, edge_flag_q};
			`ACC_OFS_ANALOG: rdata_d = {29'h00000000, analog_control_q};
			`ACC_OFS_PMODE:  rdata_d = {31'h00000000, protect_enable_bit_q};
			`ACC_OFS_PSTAT:  rdata_d = {16'h0000, violation_offset_field_q,
			                            7'h00, protect_violation_flag_q};
			default:         rdata_d = 32'h00000000;
		endcase
	end

	always @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b)
			o_prdata <= 32'h00000000;
		else if (i_psel && !i_penable && !i_pwrite)
			o_prdata <= rdata_d;
	end

	// ------------------------------------------------------------------
	// Outputs to the analog cell, fault and interrupt
	// ------------------------------------------------------------------
	assign o_minus_input_select = comparator_mode_q[`COMPARATOR_MODE_REG_MINUS_LSB +: 3];
	assign o_plus_input_select  = comparator_mode_q[`COMPARATOR_MODE_REG_PLUS_LSB +: 3];
	assign o_cmp_enable         = comparator_mode_q[`COMPARATOR_MODE_REG_EN_BIT];
	assign o_speed_low_power    = analog_control_q[`ACC_AC_CURRENT_SELECT_BIT_BIT];
	assign o_hysteresis         = analog_control_q[`ACC_AC_HYST_LSB +: 2];
	assign o_fault = comparator_mode_q[`COMPARATOR_MODE_REG_FEN_BIT] &
	                 (comparator_mode_q[`COMPARATOR_MODE_REG_FSRC_BIT] ? cmp_pol
	                                                     : edge_flag_q);
	assign o_irq = edge_flag_q & irq_mask_q;
endmodule // acc_ctrl

// file: sim/acc_props.sv
// Port checker for the comparator controller.
// Assumes it is bound to acc_ctrl, one clock, asynchronous reset.
module acc_props (
	// Clock, reset and bus
	input wire        i_mclk,
	input wire        i_rst_b,
	input wire        i_psel,
	input wire        i_penable,
	input wire        i_pwrite,
	input wire [7:0]  i_paddr,
	input wire [31:0] i_pwdata,
	// Outputs watched
	input wire        o_pready,
	input wire [2:0]  o_plus_input_select,
	input wire [2:0]  o_minus_input_select,
	input wire        o_cmp_enable,
	input wire        o_speed_low_power,
	input wire [1:0]  o_hysteresis,
	input wire        o_sel_analog_pulse,
	input wire        o_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	wire wr   = i_psel && i_penable && i_pwrite;
	wire wr_m = wr && i_paddr == 8'h04;
	wire wr_a = wr && i_paddr == 8'h94;
	wire wr_c = wr && i_paddr == 8'h00;
	wire clr  = i_psel && (i_paddr == 8'h30 || i_paddr == 8'h28 || wr_c);
	AST_ZERO_WAIT: assert property (i_psel |-> o_pready)
		else $error("pready low in a transfer");
	AST_PLUS_SEL: assert property (
		$changed(o_plus_input_select) |-> $past(wr_c) || $past(wr_m)
		&& o_plus_input_select == $past(i_pwdata[6:4]))
		else $error("plus select changed without its write");
	AST_MINUS_SEL: assert property (
		$changed(o_minus_input_select) |-> $past(wr_c) || $past(wr_m)
		&& o_minus_input_select == $past(i_pwdata[2:0]))
		else $error("minus select changed without its write");
	AST_PULSE_CAUSE: assert property (
		o_sel_analog_pulse |-> $past(wr_m) || $past(wr_m, 2))
		else $error("analog pulse without mode write");
	AST_PULSE_ONE: assert property (
		o_sel_analog_pulse |=> !o_sel_analog_pulse)
		else $error("analog pulse longer than one cycle");
	AST_HYST: assert property (
		$changed(o_hysteresis) |-> $past(wr_c) || $past(wr_a)
		&& o_hysteresis == $past(i_pwdata[2:1]))
		else $error("hysteresis changed without its write");
	AST_SPEED: assert property (
		$changed(o_speed_low_power) |-> $past(wr_c) || $past(wr_a)
		&& o_speed_low_power == $past(i_pwdata[0]))
		else $error("speed option changed without its write");
	AST_ENABLE: assert property (
		$changed(o_cmp_enable) |-> $past(wr_c) || $past(wr_m)
		&& o_cmp_enable == $past(i_pwdata[8]))
		else $error("enable changed without mode write");
	AST_IRQ_FALL: assert property (
		$fell(o_irq) |-> $past(clr) || $past(clr, 2))
		else $error("interrupt dropped without a clearing access");
endmodule // acc_props

bind acc_ctrl acc_props acc_props_inst (.i_mclk, .i_rst_b, .i_psel,
	.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready,
	.o_plus_input_select, .o_minus_input_select, .o_cmp_enable,
	.o_speed_low_power, .o_hysteresis, .o_sel_analog_pulse, .o_irq);

// file: sim/acc_cmp_model.sv
// Behavioural comparator cell: plus input 0 carries the bench level.
// Assumes the other inputs sit at fixed levels set by their index.
module acc_cmp_model (
	// Cell settings
	input  wire [2:0] i_plus_sel,
	input  wire [2:0] i_minus_sel,
	input  wire       i_enable,
	input  wire [7:0] i_level,
	// Result
	output wire       o_cmp_out
);
	timeunit 1ns;
	timeprecision 1ns;
	wire [7:0] plus_v  = (i_plus_sel == 3'h0) ? i_level : {i_plus_sel, 5'h00};
	wire [7:0] minus_v = {i_minus_sel, 5'h10};
	assign o_cmp_out = i_enable && plus_v > minus_v;
endmodule // acc_cmp_model

// file: sim/acc_ctrl_bench.sv
// Self-checking bench for the comparator controller.
// Assumes a 10 MHz clock and the behavioural comparator cell.
`include "acc_defines.vh"
module acc_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	reg         i_mclk  = 1'b0;
	reg         i_rst_b = 1'b0;
	reg         psel    = 1'b0;
	reg         pen     = 1'b0;
	reg         pwr     = 1'b0;
	reg  [7:0]  paddr   = 8'h00;
	reg  [31:0] pwdata  = 32'h0;
	reg  [7:0]  level   = 8'h00;
	reg  [31:0] q;
	wire        pready, cmp, en, lp, pulse, fault, irq;
	wire [31:0] prdata;
	wire [2:0]  ps, ms;
	wire [1:0]  hy;
	integer     fails = 0;
	integer     samples_checked = 0;

	acc_ctrl acc_ctrl_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_pready(pready), .o_pslverr(),
		.o_prdata(prdata), .i_cmp_out(cmp), .o_plus_input_select(ps),
		.o_minus_input_select(ms), .o_cmp_enable(en),
		.o_speed_low_power(lp), .o_hysteresis(hy),
		.o_sel_analog_pulse(pulse), .o_fault(fault), .o_irq(irq));
	acc_cmp_model acc_cmp_model_inst (.i_plus_sel(ps), .i_minus_sel(ms),
		.i_enable(en), .i_level(level), .o_cmp_out(cmp));

	initial begin
		forever #50 i_mclk = ~i_mclk;
	end

	task give_verdict;
		begin
			$display("checked %0d mismatches %0d", samples_checked, fails);
			if (fails == 0 && samples_checked > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask

	task chk(input [31:0] got, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("[ERR] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask

	task apb(input w, input [7:0] a, input [31:0] d);
		integer n;
		begin
			psel <= 1'b1;
			pwr <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge i_mclk);
			pen <= 1'b1;
			@(posedge i_mclk);
			for (n = 0; pready !== 1'b1 && n < 16; n = n + 1)
				@(posedge i_mclk);
			if (n == 16) begin
				fails = fails + 1;
				give_verdict;
			end
			q = prdata;
			psel <= 1'b0;
			pen <= 1'b0;
			@(posedge i_mclk);
		end
	endtask

	task wr(input [7:0] a, input [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rd(input [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task t_reset;
		integer k;
		reg [55:0] offs;
		begin
			offs = 56'h04_2c_30_94_e4_e8_08;
			chk({fault, irq, ps, ms, en, lp, hy}, 32'h0);
			for (k = 0; k < 7; k = k + 1) begin
				rd(offs[8*k+:8]);
				chk(q, 32'h0);
			end
		end
	endtask

	task t_mask;
		begin
			wr(8'h94, 32'h0);
			rd(8'h30);
			chk(q[31], 1'b1);
			repeat (10) @(posedge i_mclk);
			rd(8'h30);
			chk(q[31], 1'b0);
			wr(8'h94, 32'h1);
			repeat (100) @(posedge i_mclk);
			rd(8'h30);
			chk(q[31], 1'b1);
			repeat (30) @(posedge i_mclk);
			rd(8'h30);
			chk(q[31], 1'b0);
			wr(8'h94, 32'h6);
			chk({hy, lp}, 3'h6);
			wr(8'h04, 32'h53);
			chk({ps, ms}, 6'h2b);
		end
	endtask

	task t_edges;
		integer k, e;
		reg [1:0] t;
		reg v, h, l;
		begin
			wr(8'h24, 32'h1);
			for (k = 0; k < 4; k = k + 1) begin
				t = (k == 3) ? 2'h0 : k[1:0];
				v = (k == 3);
				wr(8'h04, {17'h0, !v, k[0], v, 1'b0, t, 1'b1, 8'h00});
				repeat (20) @(posedge i_mclk);
				rd(8'h30);
				for (e = 0; e < 2; e = e + 1) begin
					l = (e == 0);
					level <= l ? 8'hff : 8'h00;
					repeat (8) @(posedge i_mclk);
					h = (t == 2'h2) || ((t == 2'h0) == (l ^ v));
					chk(irq, h);
					chk(fault, !v && (k[0] ? l ^ v : h));
					rd(8'h30);
					chk(q[1:0], {l ^ v, h});
				end
			end
			wr(8'h04, 32'h500);
			repeat (20) @(posedge i_mclk);
			rd(8'h30);
			wr(8'h94, 32'h1);
			level <= 8'hff;
			repeat (20) @(posedge i_mclk);
			chk(irq, 1'b0);
		end
	endtask

	task t_protect;
		begin
			wr(8'he4, {`ACC_WP_KEY, 8'h01});
			wr(8'h04, 32'h7f);
			rd(8'h04);
			chk(q, 32'h500);
			rd(8'h30);
			chk(q[31], 1'b1);
			rd(8'he8);
			chk(q[15:0], 16'h0401);
			rd(8'he8);
			chk(q[0], 1'b0);
			wr(8'h94, 32'h0);
			rd(8'he8);
			chk(q[15:0], 16'h9401);
			rd(8'h94);
			chk(q, 32'h1);
			wr(8'h28, 32'h1);
			rd(8'h2c);
			chk(q, 32'h0);
			wr(8'he4, {`ACC_WP_KEY, 8'h00});
			wr(8'h00, 32'h1);
			rd(8'h04);
			chk(q, 32'h0);
		end
	endtask

	initial begin
		repeat (4) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		@(posedge i_mclk);
		t_reset;
		t_mask;
		t_edges;
		t_protect;
		give_verdict;
	end
endmodule // acc_ctrl_bench
